// ===== stm_params.svh
// Constants for the scan test mode control block.
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH
`define STM_CHAIN_LEN 8
`define STM_DRV_MAX_STRENGTH 2'h3
`define STM_DRV_NUM 2
`endif

// ===== stm_pkg.sv
// Types shared by the scan test mode control block.
package stm_pkg;
  typedef enum logic [2:0] {
    STM_FUNC = 3'h1,
    STM_SHIFT = 3'h2,
    STM_CAPTURE = 3'h4
  } stm_phase_t;
endpackage : stm_pkg

// ===== stm_scan_ctrl.sv
// Test mode pad mapping, test clock edge detection and two scan chains.
`include "stm_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - While test select is high every dual-purpose pad takes its test function.
// - In test mode both differential output drivers are forced on at maximum strength.
// - In test mode the slow test clock clocks the main and merger domains.
// - In test mode the fast test clock clocks the channel and link domains.
// - Each scan flip-flop muxes functional data or scan input under scan enable.
// - Scan flip-flops form a chain from the scan-in pad to the scan-out pad.
// - With scan enable high each rising test clock edge shifts the chain by one stage.
// - With scan enable low a single test clock pulse captures the functional response.
// - Identifier bit zero, serial inputs and diff outputs are remapped as test pads.
module stm_scan_ctrl (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_test_select,
  input wire logic i_scan_enable,
  input wire logic i_identifier_bit_zero,
  input wire logic i_serial_input_zero,
  input wire logic i_serial_input_one,
  input wire logic i_serial_input_two,
  input wire logic i_serial_input_three,
  input wire logic i_drv_enable_cfg_0,
  input wire logic i_drv_enable_cfg_1,
  input wire logic [1:0] i_drv_strength_cfg_0,
  input wire logic [1:0] i_drv_strength_cfg_1,
  input wire logic i_func_out_zero,
  input wire logic i_func_out_one,
  input wire logic [`STM_CHAIN_LEN-1:0] i_func_d_slow,
  input wire logic [`STM_CHAIN_LEN-1:0] i_func_d_fast,
  input wire logic i_main_domain_tick,
  input wire logic i_channel_domain_tick,
  output logic o_diff_output_zero,
  output logic o_diff_output_one,
  output logic o_drv_enable_0,
  output logic o_drv_enable_1,
  output logic [1:0] o_drv_strength_0,
  output logic [1:0] o_drv_strength_1,
  output logic o_pixel_matrix_test_select,
  output logic o_identifier_bit_zero,
  output logic [3:0] o_serial_inputs,
  output logic o_test_mode,
  output logic [`STM_CHAIN_LEN-1:0] o_chain_state_slow,
  output logic [`STM_CHAIN_LEN-1:0] o_chain_state_fast
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage feeds only the second stage.
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  logic tm_reg;
  logic se_reg;
  logic sclk_d_reg;
  logic fclk_d_reg;
  logic slow_rise;
  logic fast_rise;
  logic slow_edge;
  logic fast_edge;
  logic clk_quiet;
  logic [`STM_CHAIN_LEN-1:0] chain_slow_reg;
  logic [`STM_CHAIN_LEN-1:0] chain_slow_next;
  logic [`STM_CHAIN_LEN-1:0] chain_fast_reg;
  logic [`STM_CHAIN_LEN-1:0] chain_fast_next;
  stm_pkg::stm_phase_t phase_reg;

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1_reg <= 9'h000;
      sync2_reg <= 9'h000;
    end
    else
    begin
      sync1_reg <= {i_scan_enable, i_test_select, i_identifier_bit_zero, i_serial_input_zero,
                    i_serial_input_one, i_serial_input_two, i_serial_input_three,
                    i_func_out_zero, i_func_out_one};
      sync2_reg <= sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test mode is latched only while both test clocks are low so that the
  // domain clock source never changes in the middle of a pulse.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tm_reg <= 1'b0;
    end
    else if (clk_quiet)
    begin
      tm_reg <= sync2_reg[7];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      se_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      fclk_d_reg <= 1'b0;
    end
    else
    begin
      se_reg <= sync2_reg[8];
      sclk_d_reg <= sync2_reg[3];
      fclk_d_reg <= sync2_reg[2];
    end
  end

  assign slow_rise = sync2_reg[3] && !sclk_d_reg;
  assign fast_rise = sync2_reg[2] && !fclk_d_reg;
  // Leaving test mode looks at the last test clock levels, because the pads already
  // carry functional data by then and could otherwise hold test mode forever.
  assign clk_quiet = tm_reg ? (!sclk_d_reg && !fclk_d_reg)
                            : (!sync2_reg[3] && !sync2_reg[2]);
  // Slow test clock drives main and merger domains, fast drives channel and link.
  // A rise seen as test select drops is functional pad data and must not clock a chain.
  assign slow_edge = tm_reg ? (slow_rise && sync2_reg[7]) : i_main_domain_tick;
  assign fast_edge = tm_reg ? (fast_rise && sync2_reg[7]) : i_channel_domain_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Scan chains: each stage muxes functional data against the previous stage.
  always_comb
  begin
    chain_slow_next = chain_slow_reg;
    chain_fast_next = chain_fast_reg;
    if (slow_edge)
    begin
      chain_slow_next = (tm_reg && se_reg) ? {chain_slow_reg[`STM_CHAIN_LEN-2:0], sync2_reg[5]}
                                           : i_func_d_slow;
    end
    if (fast_edge)
    begin
      chain_fast_next = (tm_reg && se_reg) ? {chain_fast_reg[`STM_CHAIN_LEN-2:0], sync2_reg[4]}
                                           : i_func_d_fast;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      chain_slow_reg <= '0;
      chain_fast_reg <= '0;
    end
    else
    begin
      chain_slow_reg <= chain_slow_next;
      chain_fast_reg <= chain_fast_next;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      phase_reg <= stm_pkg::STM_FUNC;
    end
    else
    begin
      unique case (phase_reg)
        stm_pkg::STM_FUNC: if (tm_reg) phase_reg <= stm_pkg::STM_SHIFT;
        stm_pkg::STM_SHIFT: if (!tm_reg) phase_reg <= stm_pkg::STM_FUNC;
                            else if (!se_reg) phase_reg <= stm_pkg::STM_CAPTURE;
        stm_pkg::STM_CAPTURE: if (!tm_reg) phase_reg <= stm_pkg::STM_FUNC;
                              else if (se_reg) phase_reg <= stm_pkg::STM_SHIFT;
        default: phase_reg <= stm_pkg::STM_FUNC;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pad outputs, all registered.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_diff_output_zero <= 1'b0;
      o_diff_output_one <= 1'b0;
      o_drv_enable_0 <= 1'b0;
      o_drv_enable_1 <= 1'b0;
      o_drv_strength_0 <= 2'h0;
      o_drv_strength_1 <= 2'h0;
      o_pixel_matrix_test_select <= 1'b0;
      o_identifier_bit_zero <= 1'b0;
      o_serial_inputs <= 4'h0;
      o_test_mode <= 1'b0;
      o_chain_state_slow <= '0;
      o_chain_state_fast <= '0;
    end
    else
    begin
      o_test_mode <= tm_reg;
      o_diff_output_zero <= tm_reg ? chain_slow_next[`STM_CHAIN_LEN-1] : sync2_reg[1];
      o_diff_output_one <= tm_reg ? chain_fast_next[`STM_CHAIN_LEN-1] : sync2_reg[0];
      o_drv_enable_0 <= tm_reg | i_drv_enable_cfg_0;
      o_drv_enable_1 <= tm_reg | i_drv_enable_cfg_1;
      o_drv_strength_0 <= tm_reg ? `STM_DRV_MAX_STRENGTH : i_drv_strength_cfg_0;
      o_drv_strength_1 <= tm_reg ? `STM_DRV_MAX_STRENGTH : i_drv_strength_cfg_1;
      o_pixel_matrix_test_select <= tm_reg & sync2_reg[6];
      o_identifier_bit_zero <= tm_reg ? 1'b0 : sync2_reg[6];
      o_serial_inputs <= tm_reg ? 4'h0
                                : {sync2_reg[2], sync2_reg[3], sync2_reg[4], sync2_reg[5]};
      o_chain_state_slow <= chain_slow_next;
      o_chain_state_fast <= chain_fast_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_drv_forced: assert property (@(posedge i_core_clk) disable iff (i_rst)
    tm_reg |=> (o_drv_enable_0 && o_drv_enable_1 && o_drv_strength_0 == 2'h3
                && o_drv_strength_1 == 2'h3)) else $error("drivers not forced");
  chk_func_isolate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    tm_reg |=> (o_serial_inputs == 4'h0 && !o_identifier_bit_zero))
    else $error("functional pads leak in test mode");
  chk_pmts_map: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !tm_reg |=> !o_pixel_matrix_test_select) else $error("matrix select outside test");
  chk_slow_shift: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (tm_reg && sync2_reg[7] && se_reg && slow_rise) |=>
      chain_slow_reg == {$past(chain_slow_reg[`STM_CHAIN_LEN-2:0]), $past(sync2_reg[5])})
    else $error("slow chain did not shift");
  chk_fast_shift: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (tm_reg && sync2_reg[7] && se_reg && fast_rise) |=>
      chain_fast_reg == {$past(chain_fast_reg[`STM_CHAIN_LEN-2:0]), $past(sync2_reg[4])})
    else $error("fast chain did not shift");
  chk_capture_load: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (tm_reg && sync2_reg[7] && !se_reg && slow_rise) |=>
      chain_slow_reg == $past(i_func_d_slow))
    else $error("capture missed");
  chk_hold_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (tm_reg && !fast_rise) |=> $stable(chain_fast_reg)) else $error("chain moved");
  chk_scan_out: assert property (@(posedge i_core_clk) disable iff (i_rst)
    tm_reg |=> o_diff_output_zero == chain_slow_reg[`STM_CHAIN_LEN-1])
    else $error("scan out mismatch");
  chk_sel_static: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (tm_reg ? (sclk_d_reg || fclk_d_reg) : (sync2_reg[3] || sync2_reg[2])) |=>
      $stable(tm_reg))
    else $error("clock switched");
  chk_phase_capture: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (tm_reg && !se_reg && phase_reg != stm_pkg::STM_FUNC) |=>
      phase_reg == stm_pkg::STM_CAPTURE)
    else $error("capture phase not entered");

endmodule : stm_scan_ctrl

// ===== stm_tester.sv
// Tester model that drives the scan pads and the two test clocks.
module stm_tester (
  output logic o_slow_clk,
  output logic o_fast_clk,
  output logic o_scan_enable,
  output logic o_chain_a,
  output logic o_chain_b
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    o_slow_clk = 1'b0;
    o_fast_clk = 1'b0;
    o_scan_enable = 1'b1;
    o_chain_a = 1'b0;
    o_chain_b = 1'b0;
  end
  // One 125 ns frame; clocks idle low outside frames so test select may change safely.
  task automatic frame(input logic se, input logic us, input logic uf, input logic a,
                       input logic b);
    o_scan_enable = se;
    o_chain_a = a;
    o_chain_b = b;
    #60;
    o_slow_clk = us;
    o_fast_clk = uf;
    #60;
    o_slow_clk = 1'b0;
    o_fast_clk = 1'b0;
    // Hold time is over, so a late sample sees the wrong bit.
    o_chain_a = ~a;
    o_chain_b = ~b;
    #5;
  endtask : frame
endmodule : stm_tester

// ===== stm_scan_ctrl_tb.sv
// Self-checking bench for the scan test mode control block.
module stm_scan_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tsel = 1'b0;
  logic id_pad = 1'b0;
  logic mtick = 1'b0;
  logic ctick = 1'b0;
  logic [3:0] fpads = 4'h0;
  logic [5:0] cfg = 6'h00;
  logic [1:0] fout = 2'h0;
  logic [7:0] fds = 8'h00;
  logic [7:0] fdf = 8'h00;
  logic [7:0] exp_s = 8'h00;
  logic [7:0] exp_f = 8'h00;
  integer seed = 32'h7fc8;
  integer bad_count = 0;
  integer comparisons = 0;
  wire t_slow, t_fast, t_se, t_a, t_b;
  logic d0, d1, en0, en1, pmts, id_o, tmode;
  logic [1:0] st0, st1;
  logic [3:0] sers;
  logic [7:0] cs, cf;
  always #2.5 clk = ~clk;
  stm_tester tester_u (.o_slow_clk(t_slow), .o_fast_clk(t_fast), .o_scan_enable(t_se),
    .o_chain_a(t_a), .o_chain_b(t_b));
  stm_scan_ctrl dut_u (.i_core_clk(clk), .i_rst(rst), .i_test_select(tsel),
    .i_scan_enable(t_se), .i_identifier_bit_zero(id_pad),
    .i_serial_input_zero(tsel ? t_a : fpads[0]), .i_serial_input_one(tsel ? t_b : fpads[1]),
    .i_serial_input_two(tsel ? t_slow : fpads[2]),
    .i_serial_input_three(tsel ? t_fast : fpads[3]),
    .i_drv_enable_cfg_0(cfg[0]), .i_drv_enable_cfg_1(cfg[1]),
    .i_drv_strength_cfg_0(cfg[3:2]), .i_drv_strength_cfg_1(cfg[5:4]),
    .i_func_out_zero(fout[0]), .i_func_out_one(fout[1]), .i_func_d_slow(fds),
    .i_func_d_fast(fdf), .i_main_domain_tick(mtick), .i_channel_domain_tick(ctick),
    .o_diff_output_zero(d0), .o_diff_output_one(d1), .o_drv_enable_0(en0),
    .o_drv_enable_1(en1), .o_drv_strength_0(st0), .o_drv_strength_1(st1),
    .o_pixel_matrix_test_select(pmts), .o_identifier_bit_zero(id_o),
    .o_serial_inputs(sers), .o_test_mode(tmode), .o_chain_state_slow(cs),
    .o_chain_state_fast(cf));
  //////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic print_verdict;
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic check_pins(input logic [7:0] ed, input logic [3:0] es, input logic et);
    repeat (8) @(negedge clk);
    cmp("driver and id pins", ed, {en1, en0, st1, st0, pmts, id_o});
    cmp("serial copies", {4'h0, es}, {4'h0, sers});
    cmp("test mode", {7'h00, et}, {7'h00, tmode});
  endtask : check_pins
  task automatic step(input logic se, input logic us, input logic uf);
    logic a;
    logic b;
    a = $random(seed);
    b = $random(seed);
    tester_u.frame(se, us, uf, a, b);
    if (us)
      exp_s = se ? {exp_s[6:0], a} : fds;
    if (uf)
      exp_f = se ? {exp_f[6:0], b} : fdf;
    cmp("slow chain", exp_s, cs);
    cmp("fast chain", exp_f, cf);
    cmp("scan outputs", {6'h00, exp_f[7], exp_s[7]}, {6'h00, d1, d0});
  endtask : step
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    fpads = $random(seed);
    cfg = $random(seed);
    fout = $random(seed);
    fds = $random(seed);
    fdf = $random(seed);
    id_pad = $random(seed);
    check_pins({cfg[1:0], cfg[5:4], cfg[3:2], 1'b0, id_pad}, fpads, 1'b0);
    cmp("func outputs", {6'h00, fout}, {6'h00, d1, d0});
    mtick = 1'b1;
    @(negedge clk);
    mtick = 1'b0;
    ctick = 1'b1;
    @(negedge clk);
    ctick = 1'b0;
    repeat (4) @(negedge clk);
    exp_s = fds;
    exp_f = fdf;
    cmp("slow chain", exp_s, cs);
    cmp("fast chain", exp_f, cf);
    id_pad = 1'b1;
    tsel = 1'b1;
    for (int i = 0; i < 20 && tmode !== 1'b1; i++)
      @(negedge clk);
    if (tmode !== 1'b1)
    begin
      bad_count++;
      print_verdict();
    end
    check_pins(8'hFE, 4'h0, 1'b1);
    repeat (8) step(1'b1, 1'b1, 1'b1);
    step(1'b1, 1'b1, 1'b0);
    step(1'b1, 1'b0, 1'b1);
    fds = $random(seed);
    fdf = $random(seed);
    step(1'b0, 1'b1, 1'b1);
    repeat (8) step(1'b1, 1'b1, 1'b1);
    tsel = 1'b0;
    check_pins({cfg[1:0], cfg[5:4], cfg[3:2], 1'b0, 1'b1}, fpads, 1'b0);
    print_verdict();
  end
endmodule : stm_scan_ctrl_tb
